// ---- dv/branch_shift_flag_exec_bench.sv ----
// Purpose: directed instruction tests over the register bus
// Assumes: one write and one read at a time, ready lines always high
// Notes:   expectations are computed here from the flag rules
`timescale 1ns/1ps
module branch_shift_flag_exec_bench
   import bsf_pkg::*;
;
   logic              i_clock = 1'b0;
   logic              i_rst = 1'b1;
   logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
   logic              i_awvalid = 1'b0, i_wvalid = 1'b0;
   logic              i_arvalid = 1'b0;
   logic              i_bready = 1'b1, i_rready = 1'b1;
   logic [31:0]       i_wdata = '0, o_rdata, d, st;
   logic [3:0]        i_wstrb = 4'hf;
   logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0]        o_bresp, o_rresp, rs;
   logic [15:0]       o_pc, e;
   logic [7:0]        o_flags, fl, v;
   logic [6:0]        k;
   logic              tk;
   int                fails = 0, num_checks = 0, cyc = 0;
   localparam logic [7:0] FTAB [4] = '{8'h00, 8'h08, 8'hff, 8'hf7};
   localparam logic [7:0] VTAB [4] = '{8'h81, 8'h48, 8'h01, 8'h00};

   branch_shift_flag_exec i_dut (
      .i_clock, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready, .o_pc, .o_flags);

   always #4 i_clock = ~i_clock;

   // ****************
   // bus tasks
   // ****************
   task automatic axw(input logic [7:0] a, input logic [31:0] wd,
                      output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      i_awaddr <= a;
      i_wdata <= wd;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge i_clock);
         if (!aw && o_awready) begin
            aw = 1'b1;
            i_awvalid <= 1'b0;
         end
         if (!w && o_wready) begin
            w = 1'b1;
            i_wvalid <= 1'b0;
         end
      end
      do @(posedge i_clock); while (!o_bvalid);
      r = o_bresp;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] rd,
                      output logic [1:0] r);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      do @(posedge i_clock); while (!o_arready);
      i_arvalid <= 1'b0;
      do @(posedge i_clock); while (!o_rvalid);
      rd = o_rdata;
      r = o_rresp;
   endtask : axr

   // runs one instruction and returns the final status word
   task automatic ex(input logic [15:0] ins, output logic [31:0] s);
      logic [1:0] r;
      axw(OFS_INSTR, {16'h0, ins}, r);
      do axr(OFS_STAT, s, r); while (s[STAT_BUSY] !== 1'b0);
   endtask : ex

   task automatic chk(input string nm, input logic [31:0] ex_v, act);
      num_checks++;
      if (act !== ex_v) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, ex_v, act);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // ****************
   // reference models
   // ****************
   // branch conditions
   function automatic logic cond_ok(input logic [3:0] c,
                                    input logic [7:0] f);
      case (c)
         4'h0, 4'h1: return !f[FLG_C];
         4'h2: return f[FLG_C];
         4'h3: return !(f[FLG_N] ^ f[FLG_V]);
         4'h4: return f[FLG_N] ^ f[FLG_V];
         4'h5: return f[FLG_H];
         4'h6: return !f[FLG_H];
         4'h7: return f[FLG_T];
         4'h8: return !f[FLG_T];
         4'h9: return f[FLG_V];
         4'ha: return !f[FLG_V];
         4'hb: return f[FLG_I];
         default: return !f[FLG_I];
      endcase
   endfunction : cond_ok

   function automatic logic [15:0] shf(input logic [3:0] s,
                                       input logic [7:0] a, f);
      logic [7:0] r;
      logic       c;
      case (s)
         4'h0: {c, r} = {a, 1'b0};
         4'h1: {r, c} = {1'b0, a};
         4'h2: {c, r} = {a, f[FLG_C]};
         4'h3: {r, c} = {f[FLG_C], a};
         default: {r, c} = {a[7], a};
      endcase
      f[FLG_Z] = (r == 8'h00);
      f[FLG_C] = c;
      f[FLG_N] = r[7];
      f[FLG_V] = r[7] ^ c;
      if (s == 4'h0 || s == 4'h2)
         f[FLG_H] = a[3];
      return {f, r};
   endfunction : shf

   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         conclude();
      end
   end

   // ****************
   // test sequence
   // ****************
   initial begin
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      axr(OFS_PC, d, rs);
      chk("pc_rst", 32'h0, d);
      axr(8'h10, d, rs);
      chk("unmapped", {30'h0, RESP_SLV}, {30'h0, rs});
      axw(OFS_STAT, 32'h1, rs);
      chk("stat_ro", {30'h0, RESP_SLV}, {30'h0, rs});
      fl = 8'h00;
      axw(OFS_FLAGS, 32'h0, rs);
      for (int i = 0; i < 16; i++) begin
         fl[i % 8] = (i < 8);
         ex({CL_FLAG, (i < 8) ? 1'b1 : 1'b0, 3'(i % 8), 8'h00}, st);
         chk("flag_op", fl, o_flags);
      end
      for (int c = 0; c < 13; c++) begin
         for (int j = 0; j < 4; j++) begin
            fl = FTAB[j];
            k = j[0] ? 7'h7d : 7'h05;
            axw(OFS_FLAGS, {24'h0, fl}, rs);
            axw(OFS_PC, 32'h0100, rs);
            tk = cond_ok(c[3:0], fl);
            ex({CL_BRANCH, c[3:0], 1'b0, k}, st);
            e = tk ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
            chk("br_pc", e, o_pc);
            chk("br_taken", tk, st[STAT_TAKEN]);
            chk("br_cyc", tk ? CYC_TWO : CYC_ONE, st[STAT_CYC+:2]);
            chk("br_flags", fl, o_flags);
         end
      end
      for (int s = 0; s < 5; s++) begin
         for (int j = 0; j < 4; j++) begin
            v = VTAB[j];
            fl = j[0] ? 8'h31 : 8'hce;
            axw({GPR_PAGE, j[3:0], 2'b00}, {24'h0, v}, rs);
            axw(OFS_FLAGS, {24'h0, fl}, rs);
            ex({CL_SHIFT, s[3:0], 4'h0, j[3:0]}, st);
            e = shf(s[3:0], v, fl);
            axr({GPR_PAGE, j[3:0], 2'b00}, d, rs);
            chk("sh_reg", e[7:0], d);
            chk("sh_flags", e[15:8], o_flags);
         end
      end
      axw(8'h4c, 32'h20, rs);
      axw(8'h5c, 32'hf0, rs);
      axw(OFS_FLAGS, 32'h0, rs);
      ex({CL_BITX, 4'h5, 8'h03}, st);
      chk("bit_to_t", 8'h40, o_flags);
      ex({CL_BITX, 4'ha, 8'h07}, st);
      axr(8'h5c, d, rs);
      chk("t_to_bit", 32'hf4, d);
      chk("t_to_bit_fl", 8'h40, o_flags);
      ex({CL_BITX, 4'h4, 8'h03}, st);
      chk("bit_to_t0", 8'h00, o_flags);
      axw(8'ha4, 32'hff, rs);
      axw(OFS_FLAGS, 32'h3c, rs);
      ex({CL_IOCLR, 4'h6, 8'h09}, st);
      axr(8'ha4, d, rs);
      chk("io_clr", 32'hbf, d);
      chk("io_clr_fl", 8'h3c, o_flags);
      conclude();
   end
endmodule : branch_shift_flag_exec_bench

// ---- dv/branch_shift_flag_exec_properties.sv ----
// Purpose: bus handshake and activity properties of the exec unit
// Assumes: sees only the top-level ports
// Notes:   pc and flags may only move shortly after a bus write
`timescale 1ns/1ps
module branch_shift_flag_exec_checker
   import bsf_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_rst,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic              i_awvalid,
   input wire logic              o_awready,
   input wire logic [31:0]       i_wdata,
   input wire logic [3:0]        i_wstrb,
   input wire logic              i_wvalid,
   input wire logic              o_wready,
   input wire logic [1:0]        o_bresp,
   input wire logic              o_bvalid,
   input wire logic              i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic              i_arvalid,
   input wire logic              o_arready,
   input wire logic [31:0]       o_rdata,
   input wire logic [1:0]        o_rresp,
   input wire logic              o_rvalid,
   input wire logic              i_rready,
   input wire logic [15:0]       o_pc,
   input wire logic [7:0]        o_flags
);
   logic [3:0] w_age_ff;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // ****************
   // age of last write
   // ****************
   // saturates so a long idle spell never wraps into a false pass
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         w_age_ff <= 4'hf;
      end else if (i_wvalid && o_wready) begin
         w_age_ff <= 4'h0;
      end else if (w_age_ff != 4'hf) begin
         w_age_ff <= w_age_ff + 4'h1;
      end
   end

   // ****************
   // properties
   // ****************
   AST_B_TIMING: assert property (i_awvalid && o_awready && i_wvalid
      && o_wready |=> !o_bvalid ##1 o_bvalid)
      else $error("write response not two cycles after handshake");
   AST_B_DONE: assert property (o_bvalid && i_bready
      |=> !o_bvalid && o_awready && o_wready)
      else $error("write channel not reopened after response");
   AST_AW_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write accepted while response pending");
   AST_AR_RVALID: assert property (i_arvalid && o_arready
      |=> o_rvalid && !o_arready)
      else $error("read data not one cycle after address");
   AST_R_DONE: assert property (o_rvalid && i_rready
      |=> !o_rvalid && o_arready)
      else $error("read channel not reopened after data");
   AST_SLV_ZERO: assert property (o_rvalid && o_rresp == RESP_SLV
      |-> o_rdata == 32'h0)
      else $error("refused read returned nonzero data");
   AST_FLAGS_CAUSE: assert property (
      $changed(o_flags) |-> w_age_ff <= 4'h5)
      else $error("flags moved without a write");
   AST_PC_CAUSE: assert property (
      $changed(o_pc) |-> w_age_ff <= 4'h6)
      else $error("pc moved without a write");

   cover property (o_rvalid && o_rresp == RESP_SLV);
   cover property (o_bvalid && o_bresp == RESP_SLV);
   cover property ($changed(o_pc));
endmodule : branch_shift_flag_exec_checker

bind branch_shift_flag_exec branch_shift_flag_exec_checker i_chk (
   .i_clock, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
   .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
   .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
   .i_rready, .o_pc, .o_flags);

// ---- hdl/branch_shift_flag_exec.sv ----
// Purpose: executes branch, shift, bit-transfer and flag instructions
// Assumes: instructions are written over AXI4-Lite, one at a time
// Notes:   state, working registers and I/O bytes are bus visible
//
// What this block does
// - carry clear/lower branches test carry
// - signed ge branch when N xor V 0
// - signed lt branch when N xor V 1
// - half-carry branches test H
// - transfer branches test T flag
// - overflow branches test V flag
// - interrupt branches test I flag
// - left shift, zero in, ZCNVH updated
// - right shift, zero in, ZCNV updated
// - rotate left through carry, ZCNVH
// - rotate right through carry, ZCNV
// - arithmetic right shift, ZCNV, one cycle
// - clear one I/O bit, flags untouched
// - register bit copied into T
// - T copied into register bit
// - set or clear each flag alone
// - interrupt flag set or cleared alone
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module branch_shift_flag_exec
   import bsf_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   output logic [1:0]             o_bresp,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [15:0]            o_pc,
   output logic [7:0]             o_flags
);

   // ***************************************************
   // functions
   // ***************************************************
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic cond_met(input logic [3:0] c,
                                     input logic [7:0] f);
      case (cond_t'(c))
         BR_CARRY_CLEAR,
         BR_SAME_HIGHER:  return ~f[FLG_C];
         BR_LOWER:        return f[FLG_C];
         BR_SIGNED_GE:    return ~(f[FLG_N] ^ f[FLG_V]);
         BR_SIGNED_LT:    return f[FLG_N] ^ f[FLG_V];
         BR_HC_SET:       return f[FLG_H];
         BR_HC_CLEAR:     return ~f[FLG_H];
         BR_T_SET:        return f[FLG_T];
         BR_T_CLEAR:      return ~f[FLG_T];
         BR_V_SET:        return f[FLG_V];
         BR_V_CLEAR:      return ~f[FLG_V];
         BR_IRQ_ENABLED:  return f[FLG_I];
         BR_IRQ_DISABLED: return ~f[FLG_I];
         default:         return 1'b0;
      endcase
   endfunction : cond_met

   // returns {result, flags}
   function automatic logic [15:0] shift_exec(input logic [3:0] k,
                                              input logic [7:0] v,
                                              input logic [7:0] f);
      logic [7:0] r;
      logic [7:0] nf;
      logic       c;
      logic       hit;
      r   = v;
      nf  = f;
      c   = f[FLG_C];
      hit = 1'b1;
      case (shift_t'(k))
         SH_LEFT_LOG: begin
            r = {v[6:0], 1'b0};
            c = v[7];
         end
         SH_RIGHT_LOG: begin
            r = {1'b0, v[7:1]};
            c = v[0];
         end
         SH_ROT_LEFT: begin
            r = {v[6:0], f[FLG_C]};
            c = v[7];
         end
         SH_ROT_RIGHT: begin
            r = {f[FLG_C], v[7:1]};
            c = v[0];
         end
         SH_RIGHT_AR: begin
            r = {v[7], v[7:1]};
            c = v[0];
         end
         default: hit = 1'b0;
      endcase
      if (hit) begin
         nf[FLG_Z] = (r == 8'h00);
         nf[FLG_C] = c;
         nf[FLG_N] = r[7];
         nf[FLG_V] = r[7] ^ c;
         // half carry only for the left moves
         if (shift_t'(k) == SH_LEFT_LOG || shift_t'(k) == SH_ROT_LEFT) begin
            nf[FLG_H] = v[3];
         end
      end
      return {r, nf};
   endfunction : shift_exec

   // ***************************************************
   // state
   // ***************************************************
   state_t      state_ff;
   instr_t      ir_ff;
   logic [15:0] pc_ff;
   logic [15:0] target_ff;
   logic [7:0]  flags_ff;
   logic [1:0]  cyc_ff;
   logic        taken_ff;
   logic [7:0]  gpr_ff [NUM_GPR];
   logic [7:0]  io_ff  [NUM_IO];
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        have_aw_ff;
   logic        have_w_ff;

   // ***************************************************
   // execution decode
   // ***************************************************
   logic        exec_now;
   logic        taken;
   logic        wr_gpr;
   logic        wr_io;
   logic [7:0]  rd_val;
   logic [7:0]  io_val;
   logic [7:0]  nxt_res;
   logic [7:0]  nxt_io;
   logic [7:0]  nxt_flags;
   logic [15:0] nxt_target;

   assign exec_now = (state_ff == ST_EXEC);
   assign rd_val   = gpr_ff[ir_ff.data[3:0]];
   assign io_val   = io_ff[ir_ff.data[4:0]];
   assign nxt_target = pc_ff + {{9{ir_ff.data[6]}}, ir_ff.data[6:0]}
                       + 16'h0001;

   always_comb begin
      taken     = 1'b0;
      wr_gpr    = 1'b0;
      wr_io     = 1'b0;
      nxt_res   = rd_val;
      nxt_io    = io_val;
      nxt_flags = flags_ff;
      case (ir_ff.cls)
         CL_BRANCH: taken = cond_met(ir_ff.sub, flags_ff);
         CL_SHIFT: begin
            {nxt_res, nxt_flags} = shift_exec(ir_ff.sub, rd_val, flags_ff);
            wr_gpr = 1'b1;
         end
         CL_BITX: begin
            if (ir_ff.sub[3]) begin
               nxt_res[ir_ff.sub[2:0]] = flags_ff[FLG_T];
               wr_gpr = 1'b1;
            end else begin
               nxt_flags[FLG_T] = rd_val[ir_ff.sub[2:0]];
            end
         end
         CL_IOCLR: begin
            nxt_io = io_val & ~(8'h01 << ir_ff.sub[2:0]);
            wr_io  = 1'b1;
         end
         CL_FLAG: nxt_flags[ir_ff.sub[2:0]] = ir_ff.sub[3];
         default: ;
      endcase
   end

   // ***************************************************
   // bus write side
   // ***************************************************
   logic        wr_go;
   logic        wr_err;
   logic        busy;
   logic [1:0]  wpage;
   assign busy  = (state_ff != ST_IDLE);
   assign wr_go = have_aw_ff & have_w_ff & ~o_bvalid;
   assign wpage = awaddr_ff[7:6];
   assign wr_err = (awaddr_ff[1:0] != 2'h0)
                 | ((wpage == 2'h0) && (awaddr_ff[5:0] > OFS_FLAGS[5:0]));

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         have_aw_ff <= 1'b0;
         have_w_ff  <= 1'b0;
         awaddr_ff  <= '0;
         wdata_ff   <= '0;
         wstrb_ff   <= '0;
         o_awready  <= 1'b1;
         o_wready   <= 1'b1;
         o_bvalid   <= 1'b0;
         o_bresp    <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            awaddr_ff  <= i_awaddr;
            have_aw_ff <= 1'b1;
            o_awready  <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            wdata_ff  <= i_wdata;
            wstrb_ff  <= i_wstrb;
            have_w_ff <= 1'b1;
            o_wready  <= 1'b0;
         end
         if (wr_go) begin
            have_aw_ff <= 1'b0;
            have_w_ff  <= 1'b0;
            o_bvalid   <= 1'b1;
            o_bresp    <= wr_err ? RESP_SLV : RESP_OKAY;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // software writes land only while idle; execution owns state otherwise
   logic sw_wr;
   assign sw_wr = wr_go & ~wr_err & ~busy;

   // ***************************************************
   // sequencer, program counter and flags
   // ***************************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_ff  <= ST_IDLE;
         ir_ff     <= '0;
         pc_ff     <= RST_PC;
         target_ff <= RST_PC;
         flags_ff  <= RST_FLAGS;
         cyc_ff    <= '0;
         taken_ff  <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (sw_wr && wpage == 2'h0) begin
                  case (awaddr_ff)
                     OFS_INSTR: begin
                        ir_ff    <= wdata_ff[15:0];
                        state_ff <= ST_EXEC;
                     end
                     OFS_PC: pc_ff <= 16'(merge({16'h0, pc_ff}, wdata_ff,
                                                wstrb_ff));
                     OFS_FLAGS: flags_ff <= 8'(merge({24'h0, flags_ff},
                                                wdata_ff, wstrb_ff));
                     default: ;
                  endcase
               end
            end
            ST_EXEC: begin
               flags_ff <= nxt_flags;
               taken_ff <= taken;
               if (taken) begin
                  target_ff <= nxt_target;
                  state_ff  <= ST_TAKEN;
               end else begin
                  pc_ff    <= pc_ff + 16'h0001;
                  cyc_ff   <= CYC_ONE;
                  state_ff <= ST_IDLE;
               end
            end
            ST_TAKEN: begin
               pc_ff    <= target_ff;
               cyc_ff   <= CYC_TWO;
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************
   // working registers and I/O bytes
   // ***************************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_GPR; i++) gpr_ff[i] <= 8'h00;
         for (int i = 0; i < NUM_IO; i++)  io_ff[i]  <= 8'h00;
      end else if (exec_now) begin
         if (wr_gpr) gpr_ff[ir_ff.data[3:0]] <= nxt_res;
         if (wr_io)  io_ff[ir_ff.data[4:0]]  <= nxt_io;
      end else if (sw_wr && wstrb_ff[0]) begin
         if (wpage == GPR_PAGE) gpr_ff[awaddr_ff[5:2]] <= wdata_ff[7:0];
         if (awaddr_ff[7] == IO_PAGE) io_ff[awaddr_ff[6:2]] <= wdata_ff[7:0];
      end
   end

   // ***************************************************
   // bus read side
   // ***************************************************
   logic [31:0] rd_word;
   logic        rd_err;
   always_comb begin
      rd_word = 32'h0;
      rd_err  = (i_araddr[1:0] != 2'h0);
      if (i_araddr[7] == IO_PAGE) begin
         rd_word[7:0] = io_ff[i_araddr[6:2]];
      end else if (i_araddr[7:6] == GPR_PAGE) begin
         rd_word[7:0] = gpr_ff[i_araddr[5:2]];
      end else begin
         case ({i_araddr[7:2], 2'h0})
            OFS_INSTR: rd_word[15:0] = ir_ff;
            OFS_PC:    rd_word[15:0] = pc_ff;
            OFS_FLAGS: rd_word[7:0]  = flags_ff;
            OFS_STAT: begin
               rd_word[STAT_BUSY]       = busy;
               rd_word[STAT_TAKEN]      = taken_ff;
               rd_word[STAT_CYC +: 2]   = cyc_ff;
            end
            default: rd_err = 1'b1;
         endcase
      end
      if (rd_err) begin
         rd_word = 32'h0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rd_word;
         o_rresp   <= rd_err ? RESP_SLV : RESP_OKAY;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ***************************************************
   // visible state
   // ***************************************************
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pc    <= RST_PC;
         o_flags <= RST_FLAGS;
      end else begin
         o_pc    <= pc_ff;
         o_flags <= flags_ff;
      end
   end

endmodule : branch_shift_flag_exec

// ---- hdl/bsf_pkg.sv ----
// Purpose: shared constants and types for the branch/shift/flag unit
// Assumes: 8-bit AXI4-Lite byte addresses, 32-bit data
// Notes:   instruction encoding is local to this unit
package bsf_pkg;
   localparam int          ADDR_W    = 8;
   localparam int          NUM_GPR   = 16;
   localparam int          NUM_IO    = 32;
   // register map (byte addresses)
   localparam logic [7:0]  OFS_INSTR = 8'h00;
   localparam logic [7:0]  OFS_PC    = 8'h04;
   localparam logic [7:0]  OFS_FLAGS = 8'h08;
   localparam logic [7:0]  OFS_STAT  = 8'h0c;
   localparam logic [1:0]  GPR_PAGE  = 2'h1;   // 0x40..0x7c
   localparam logic [0:0]  IO_PAGE   = 1'h1;   // 0x80..0xfc
   // status word fields
   localparam int          STAT_BUSY  = 0;
   localparam int          STAT_TAKEN = 4;
   localparam int          STAT_CYC   = 8;
   // flag positions inside status_flags
   localparam int          FLG_C = 0;
   localparam int          FLG_Z = 1;
   localparam int          FLG_N = 2;
   localparam int          FLG_V = 3;
   localparam int          FLG_S = 4;
   localparam int          FLG_H = 5;
   localparam int          FLG_T = 6;
   localparam int          FLG_I = 7;
   // reset values and cycle figures
   localparam logic [15:0] RST_PC    = 16'h0000;
   localparam logic [7:0]  RST_FLAGS = 8'h00;
   localparam logic [1:0]  CYC_ONE   = 2'h1;
   localparam logic [1:0]  CYC_TWO   = 2'h2;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLV  = 2'h2;

   typedef enum logic [3:0] {
      CL_BRANCH = 4'h1,
      CL_SHIFT  = 4'h2,
      CL_BITX   = 4'h3,
      CL_IOCLR  = 4'h4,
      CL_FLAG   = 4'h5
   } class_t;

   typedef enum logic [3:0] {
      BR_CARRY_CLEAR  = 4'h0,
      BR_SAME_HIGHER  = 4'h1,
      BR_LOWER        = 4'h2,
      BR_SIGNED_GE    = 4'h3,
      BR_SIGNED_LT    = 4'h4,
      BR_HC_SET       = 4'h5,
      BR_HC_CLEAR     = 4'h6,
      BR_T_SET        = 4'h7,
      BR_T_CLEAR      = 4'h8,
      BR_V_SET        = 4'h9,
      BR_V_CLEAR      = 4'ha,
      BR_IRQ_ENABLED  = 4'hb,
      BR_IRQ_DISABLED = 4'hc
   } cond_t;

   typedef enum logic [3:0] {
      SH_LEFT_LOG  = 4'h0,
      SH_RIGHT_LOG = 4'h1,
      SH_ROT_LEFT  = 4'h2,
      SH_ROT_RIGHT = 4'h3,
      SH_RIGHT_AR  = 4'h4
   } shift_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_EXEC  = 2'b01,
      ST_TAKEN = 2'b10
   } state_t;

   typedef struct packed {
      class_t      cls;
      logic [3:0]  sub;
      logic [7:0]  data;
   } instr_t;
endpackage : bsf_pkg
